/* File: rtl/aecr_pkg.sv */
// Purpose : Constants for the extended-control register bank.
// Assumes : 16-bit registers, 4-bit serial addresses.
// Notes   : Shared by the bank and its bench.
package aecr_pkg;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int          FRAME_BITS   = 32;
    localparam logic [4:0]  LAST_BIT_IDX = 5'h1F;
    localparam logic [11:0] FRAME_HEADER = 12'h001;
    localparam int          HDR_MSB      = 31;
    localparam int          HDR_LSB      = 20;
    localparam int          ADR_MSB      = 19;
    localparam int          ADR_LSB      = 16;
    localparam int          DAT_MSB      = 15;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CFG      = 4'h1;
    localparam logic [3:0] ADDR_OFS1     = 4'h2;
    localparam logic [3:0] ADDR_FS1      = 4'h3;
    localparam logic [3:0] ADDR_OFS2     = 4'hA;
    localparam logic [3:0] ADDR_FS2      = 4'hB;
    localparam logic [3:0] ADDR_ILV_EN   = 4'hD;
    localparam logic [3:0] ADDR_COARSE   = 4'hE;
    localparam logic [3:0] ADDR_FINE     = 4'hF;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CFG_RST      = 16'hB2FF;
    localparam logic [15:0] OFS_RST      = 16'h007F;
    localparam logic [15:0] FS_RST       = 16'h807F;
    localparam logic [15:0] ILV_EN_RST   = 16'h3FFF;
    localparam logic [15:0] COARSE_RST   = 16'h07FF;
    localparam logic [15:0] FINE_RST     = 16'h007F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_DCS_BIT   = 12;
    localparam int CFG_DCP_BIT   = 11;
    localparam int CFG_SDR_BIT   = 10;
    localparam int CFG_SWING_BIT = 9;
    localparam int CFG_EDGE_BIT  = 8;
    localparam int OFS_MAG_MSB   = 15;
    localparam int OFS_MAG_LSB   = 8;
    localparam int OFS_SIGN_BIT  = 7;
    localparam int FS_MSB        = 15;
    localparam int FS_LSB        = 7;
    localparam int ILV_ON_BIT    = 15;
    localparam int ILV_ACP_BIT   = 14;
    localparam int CRS_IS_BIT    = 15;
    localparam int CRS_ADS_BIT   = 14;
    localparam int CRS_MAG_MSB   = 13;
    localparam int CRS_MAG_LSB   = 11;
    localparam int FINE_MSB      = 15;
    localparam int FINE_LSB      = 7;

    // ------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SHIFT  = 3'b010,
        ST_COMMIT = 3'b100
    } aecr_state_t;

endpackage : aecr_pkg

/* File: rtl/aecr_sync.sv */
// Purpose : Two-flop synchroniser for pins entering clk_sys.
// Assumes : Inputs are slow levels relative to clk_sys.
// Notes   : First stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module aecr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule : aecr_sync
`default_nettype wire

/* File: rtl/aecr_top.sv */
// Purpose : Write-only extended-control register bank, serial loaded.
// Assumes : Serial pins oversampled by clk_sys, at least 6 clk per bit.
// Notes   : All settings fall back to pin/default values in normal mode.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Configuration bit 12 turns the duty-cycle stabilizer on.
// - Bit 11 shifts DDR clock to mid-cell; ignored in single rate.
// - Bit 10 zero gives double rate, one gives single rate.
// - Bit 9 selects swing, one standard, reset one, like pin.
// - Bit 8 picks rising or falling output edge in single rate.
// - Offset bits 15:8 give linear offset magnitude, reset zero.
// - Offset bit 7 is sign, one negative; host writes 6:0 ones.
// - Full-scale code in bits 15:7, reset 100000000, linear trim.
// - Full-scale changes apply at once, no recalibration step.
// - Interleave bit 15 makes both converters share one input.
// - Bit 14 enables automatic phase; manual skew then ignored.
// - Coarse bit 15 chooses which input is shared when interleaved.
// - Coarse bit 14 chooses which channel clock is delayed.
// - Coarse bits 13:11 give skew steps, reset zero; rest ones.
// - Fine bits 15:7 give fine skew, reset zero; rest ones.
// - Eight write-only registers with fixed power-on values.
// - Frame is 32 bits MSB first: header 0x001, address, data.
// - Select low frames access; next frame may follow directly.
// - Settings and serial port act only in extended mode.
module aecr_top
    import aecr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       ser_clk,
    input  wire logic       ser_din,
    input  wire logic       ser_select_n,
    input  wire logic       ext_mode,
    input  wire logic       edge_choice_pin,
    input  wire logic       swing_choice_pin,
    output logic            duty_stabilizer_on,
    output logic            ddr_clock_phase_sel,
    output logic            single_rate_select,
    output logic            swing_level_sel,
    output logic            out_edge_rising,
    output logic [7:0]      first_offset_mag,
    output logic            first_offset_neg,
    output logic [8:0]      first_full_scale,
    output logic [7:0]      second_offset_mag,
    output logic            second_offset_neg,
    output logic [8:0]      second_full_scale,
    output logic            interleave_on,
    output logic            auto_phase_control,
    output logic            shared_input_choice,
    output logic            skew_target_select,
    output logic [2:0]      coarse_skew_magnitude,
    output logic [8:0]      fine_skew_magnitude,
    output logic            frame_done,
    output logic            frame_bad
);

    // ------------------------------------------------------------
    // Pin synchronisation and edge finding
    // ------------------------------------------------------------
    logic [5:0]  pins_sync;
    logic        sclk_s;
    logic        din_s;
    logic        sel_n_s;
    logic        ext_s;
    logic        edge_pin_s;
    logic        swing_pin_s;
    logic        sclk_prev_ff;
    logic        sclk_rise;

    aecr_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .async_in ({ser_clk, ser_din, ser_select_n, ext_mode,
                    edge_choice_pin, swing_choice_pin}),
        .sync_out (pins_sync)
    );

    // Clock and data share a stage, so data is seen with its edge
    assign sclk_s      = pins_sync[5];
    assign din_s       = pins_sync[4];
    assign sel_n_s     = pins_sync[3];
    assign ext_s       = pins_sync[2];
    assign edge_pin_s  = pins_sync[1];
    assign swing_pin_s = pins_sync[0];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_ff;

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    aecr_state_t state_ff;
    aecr_state_t nxt_state;
    logic [4:0]  bit_cnt_ff;
    logic [31:0] shift_ff;
    logic        port_on;
    logic        take_bit;
    logic        last_bit;
    logic [11:0] frm_hdr;
    logic [3:0]  frm_addr;
    logic [15:0] frm_data;
    logic        addr_ok;
    logic        frame_ok;

    function automatic logic is_mapped(input logic [3:0] a);
        case (a)
            ADDR_CFG, ADDR_OFS1, ADDR_FS1, ADDR_OFS2,
            ADDR_FS2, ADDR_ILV_EN, ADDR_COARSE, ADDR_FINE: is_mapped = 1'b1;
            default:                                     is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    assign port_on  = ext_s & ~sel_n_s;
    assign take_bit = (state_ff == ST_SHIFT) && port_on && sclk_rise;
    assign last_bit = take_bit && (bit_cnt_ff == LAST_BIT_IDX);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (port_on) begin
                    nxt_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!port_on) begin
                    nxt_state = ST_IDLE;
                end else if (last_bit) begin
                    nxt_state = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                nxt_state = port_on ? ST_SHIFT : ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shift_ff <= 32'h0000_0000;
        end else if (take_bit) begin
            shift_ff <= {shift_ff[30:0], din_s};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bit_cnt_ff <= 5'h00;
        end else if (state_ff != ST_SHIFT || !port_on) begin
            bit_cnt_ff <= 5'h00;
        end else if (take_bit) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    assign frm_hdr  = shift_ff[HDR_MSB:HDR_LSB];
    assign frm_addr = shift_ff[ADR_MSB:ADR_LSB];
    assign frm_data = shift_ff[DAT_MSB:0];
    assign addr_ok  = is_mapped(frm_addr);
    assign frame_ok = (state_ff == ST_COMMIT) && (frm_hdr == FRAME_HEADER)
                      && addr_ok;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            frame_done <= 1'b0;
            frame_bad  <= 1'b0;
        end else begin
            frame_done <= frame_ok;
            frame_bad  <= (state_ff == ST_COMMIT) && !frame_ok;
        end
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    logic [15:0] cfg_ff;
    logic [15:0] ofs1_ff;
    logic [15:0] fs1_ff;
    logic [15:0] ofs2_ff;
    logic [15:0] fs2_ff;
    logic [15:0] ilv_ff;
    logic [15:0] coarse_ff;
    logic [15:0] fine_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_ff    <= CFG_RST;
            ofs1_ff   <= OFS_RST;
            fs1_ff    <= FS_RST;
            ofs2_ff   <= OFS_RST;
            fs2_ff    <= FS_RST;
            ilv_ff    <= ILV_EN_RST;
            coarse_ff <= COARSE_RST;
            fine_ff   <= FINE_RST;
        end else if (frame_ok) begin
            case (frm_addr)
                ADDR_CFG:    cfg_ff    <= frm_data;
                ADDR_OFS1:   ofs1_ff   <= frm_data;
                ADDR_FS1:    fs1_ff    <= frm_data;
                ADDR_OFS2:   ofs2_ff   <= frm_data;
                ADDR_FS2:    fs2_ff    <= frm_data;
                ADDR_ILV_EN: ilv_ff    <= frm_data;
                ADDR_COARSE: coarse_ff <= frm_data;
                ADDR_FINE:   fine_ff   <= frm_data;
                default:     cfg_ff    <= cfg_ff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Effective control outputs
    // ------------------------------------------------------------
    // Reserved "ones" bits are stored but drive nothing, so a host
    // slip there cannot disturb the block.
    logic sdr_mode;
    logic auto_on;

    assign sdr_mode = cfg_ff[CFG_SDR_BIT];
    assign auto_on  = ilv_ff[ILV_ACP_BIT];

    // normal mode uses pins and defaults
    always_ff @(posedge clk_sys) begin
        if (reset || !ext_s) begin
            duty_stabilizer_on  <= CFG_RST[CFG_DCS_BIT];
            ddr_clock_phase_sel <= 1'b0;
            single_rate_select  <= CFG_RST[CFG_SDR_BIT];
            swing_level_sel     <= reset ? CFG_RST[CFG_SWING_BIT]
                                         : swing_pin_s;
            out_edge_rising     <= reset ? CFG_RST[CFG_EDGE_BIT]
                                         : edge_pin_s;
        end else begin
            duty_stabilizer_on  <= cfg_ff[CFG_DCS_BIT];
            ddr_clock_phase_sel <= cfg_ff[CFG_DCP_BIT] & ~sdr_mode;
            single_rate_select  <= sdr_mode;
            swing_level_sel     <= cfg_ff[CFG_SWING_BIT];
            out_edge_rising     <= cfg_ff[CFG_EDGE_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || !ext_s) begin
            first_offset_mag  <= OFS_RST[OFS_MAG_MSB:OFS_MAG_LSB];
            first_offset_neg  <= OFS_RST[OFS_SIGN_BIT];
            second_offset_mag <= OFS_RST[OFS_MAG_MSB:OFS_MAG_LSB];
            second_offset_neg <= OFS_RST[OFS_SIGN_BIT];
            first_full_scale  <= FS_RST[FS_MSB:FS_LSB];
            second_full_scale <= FS_RST[FS_MSB:FS_LSB];
        end else begin
            first_offset_mag  <= ofs1_ff[OFS_MAG_MSB:OFS_MAG_LSB];
            second_offset_mag <= ofs2_ff[OFS_MAG_MSB:OFS_MAG_LSB];
            first_offset_neg  <= ofs1_ff[OFS_SIGN_BIT];
            second_offset_neg <= ofs2_ff[OFS_SIGN_BIT];
            first_full_scale  <= fs1_ff[FS_MSB:FS_LSB];
            second_full_scale <= fs2_ff[FS_MSB:FS_LSB];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || !ext_s) begin
            interleave_on         <= 1'b0;
            auto_phase_control    <= ILV_EN_RST[ILV_ACP_BIT];
            shared_input_choice   <= COARSE_RST[CRS_IS_BIT];
            skew_target_select    <= COARSE_RST[CRS_ADS_BIT];
            coarse_skew_magnitude <= COARSE_RST[CRS_MAG_MSB:CRS_MAG_LSB];
            fine_skew_magnitude   <= FINE_RST[FINE_MSB:FINE_LSB];
        end else begin
            interleave_on         <= ilv_ff[ILV_ON_BIT];
            auto_phase_control    <= auto_on;
            shared_input_choice   <= coarse_ff[CRS_IS_BIT];
            skew_target_select    <= coarse_ff[CRS_ADS_BIT];
            coarse_skew_magnitude <= auto_on ? 3'h0
                                   : coarse_ff[CRS_MAG_MSB:CRS_MAG_LSB];
            fine_skew_magnitude   <= auto_on ? 9'h000
                                   : fine_ff[FINE_MSB:FINE_LSB];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_por_values;
        @(posedge clk_sys) $fell(reset) |-> (cfg_ff == CFG_RST)
            && (ilv_ff == ILV_EN_RST) && (fs1_ff == FS_RST)
            && (fs2_ff == FS_RST) && (ofs1_ff == OFS_RST) && (ofs2_ff == OFS_RST)
            && (coarse_ff == COARSE_RST) && (fine_ff == FINE_RST);
    endproperty
    a_por_values: assert property (p_por_values)
        else $error("register power-on value wrong");

    property p_bad_frame_keeps;
        (state_ff == ST_COMMIT) && !frame_ok |=> $stable(cfg_ff)
            && $stable(ofs1_ff) && $stable(fs1_ff) && $stable(ofs2_ff)
            && $stable(fs2_ff) && $stable(ilv_ff) && $stable(coarse_ff)
            && $stable(fine_ff) ##1 frame_bad == 1'b0;
    endproperty
    a_bad_frame_keeps: assert property (p_bad_frame_keeps)
        else $error("rejected frame changed a register");

    property p_commit_after_32;
        (state_ff == ST_COMMIT) |-> $past(bit_cnt_ff) == LAST_BIT_IDX
            && $past(take_bit);
    endproperty
    a_commit_after_32: assert property (p_commit_after_32)
        else $error("frame committed at wrong bit count");

    property p_cfg_write;
        frame_ok && (frm_addr == ADDR_CFG) |=> cfg_ff == $past(frm_data)
            ##1 single_rate_select == cfg_ff[CFG_SDR_BIT];
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration write not applied");

    property p_fs_immediate;
        frame_ok && (frm_addr == ADDR_FS1) && ext_s ##1 ext_s
            |=> first_full_scale == $past(frm_data[FS_MSB:FS_LSB], 2);
    endproperty
    a_fs_immediate: assert property (p_fs_immediate)
        else $error("full-scale trim not applied within two cycles");

    property p_phase_ddr_only;
        single_rate_select |-> !ddr_clock_phase_sel;
    endproperty
    a_phase_ddr_only: assert property (p_phase_ddr_only)
        else $error("DDR phase active in single rate");

    property p_auto_masks;
        auto_phase_control |-> coarse_skew_magnitude == 3'h0
            && fine_skew_magnitude == 9'h000;
    endproperty
    a_auto_masks: assert property (p_auto_masks)
        else $error("manual skew leaked in auto phase mode");

    property p_normal_mode;
        (!ext_s && !reset) [*2] |-> !interleave_on
            && swing_level_sel == $past(swing_pin_s)
            && duty_stabilizer_on == CFG_RST[CFG_DCS_BIT];
    endproperty
    a_normal_mode: assert property (p_normal_mode)
        else $error("register setting active in normal mode");

    property p_select_abort;
        $rose(sel_n_s) |=> bit_cnt_ff == 5'h00 && state_ff != ST_COMMIT;
    endproperty
    a_select_abort: assert property (p_select_abort)
        else $error("frame not aborted on select release");

    property p_dcs_follows;
        ext_s && $stable(cfg_ff) && $past(ext_s)
            |=> duty_stabilizer_on == $past(cfg_ff[CFG_DCS_BIT]);
    endproperty
    a_dcs_follows: assert property (p_dcs_follows)
        else $error("stabilizer output does not follow bit 12");

    c_good_frame: cover property (frame_done);
    c_bad_frame:  cover property (frame_bad);
    c_back2back:  cover property (frame_done ##[1:400] frame_done);
    c_interleave: cover property (interleave_on && auto_phase_control);

endmodule : aecr_top
`default_nettype wire

/* File: verification/aecr_host.sv */
// Purpose : Host model driving the three-wire serial write port.
// Assumes : Serial clock half period is half clk_sys cycles (4 = 80 ns).
// Notes   : Serial clock stands low and data keeps moving between frames.
`timescale 1ns/10ps
`default_nettype none
module aecr_host (
    input  wire logic clk_sys,
    output logic      ser_clk,
    output logic      ser_din,
    output logic      ser_select_n
);
    int half = 4;
    initial begin
        ser_clk      = 1'b0;
        ser_din      = 1'b0;
        ser_select_n = 1'b1;
    end
    // Released data line has no pull: never leave the last bit
    always @(posedge clk_sys) begin
        if (ser_select_n) ser_din <= ~ser_din;
    end
    task automatic send(input logic [31:0] frm, input int nbits,
                        input bit keep);
        ser_select_n <= 1'b0;
        repeat (half) @(posedge clk_sys);
        for (int i = 31; i > 31 - nbits; i--) begin
            ser_din <= frm[i];
            repeat (half) @(posedge clk_sys);
            ser_clk <= 1'b1;
            repeat (half) @(posedge clk_sys);
            ser_clk <= 1'b0;
        end
        if (!keep) ser_select_n <= 1'b1;
        @(posedge clk_sys);
    endtask : send
endmodule : aecr_host
`default_nettype wire

/* File: verification/test_aecr_top.sv */
// Purpose : Self-checking bench for the serial register bank.
// Assumes : 50 MHz clk_sys; the host model paces the serial clock.
// Notes   : Each wr frame queues its expected outputs; pulses pop them.
`timescale 1ns/10ps
`default_nettype none
module test_aecr_top;
    import aecr_pkg::*;
    logic        clk_sys, reset, ext_mode, edge_choice_pin, swing_choice_pin;
    wire         ser_clk, ser_din, ser_select_n, frame_done, frame_bad;
    wire         duty_stabilizer_on, ddr_clock_phase_sel, single_rate_select;
    wire         swing_level_sel, out_edge_rising, first_offset_neg;
    wire         second_offset_neg, interleave_on, auto_phase_control;
    wire         shared_input_choice, skew_target_select;
    wire [7:0]   first_offset_mag, second_offset_mag;
    wire [8:0]   first_full_scale, second_full_scale, fine_skew_magnitude;
    wire [2:0]   coarse_skew_magnitude;
    wire [56:0]  obs;
    logic [15:0] rg [16];
    logic [15:0] rst [16];
    logic [58:0] exq [$];
    logic [3:0]  adr [8] = '{ADDR_ILV_EN, ADDR_CFG, ADDR_OFS1, ADDR_FS1,
                             ADDR_OFS2, ADDR_FS2, ADDR_COARSE, ADDR_FINE};
    logic [3:0]  rsv [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC};
    logic [1:0]  pulse;
    int          n_fail, num_checks;

    assign obs = {duty_stabilizer_on, ddr_clock_phase_sel, single_rate_select,
        swing_level_sel, out_edge_rising, first_offset_mag, first_offset_neg,
        first_full_scale, second_offset_mag, second_offset_neg,
        second_full_scale, interleave_on, auto_phase_control,
        shared_input_choice, skew_target_select, coarse_skew_magnitude,
        fine_skew_magnitude};

    aecr_host u_aecr_host (.clk_sys, .ser_clk, .ser_din, .ser_select_n);
    aecr_top u_aecr_top (.clk_sys, .reset, .ser_clk, .ser_din, .ser_select_n,
        .ext_mode, .edge_choice_pin, .swing_choice_pin, .duty_stabilizer_on,
        .ddr_clock_phase_sel, .single_rate_select, .swing_level_sel,
        .out_edge_rising, .first_offset_mag, .first_offset_neg,
        .first_full_scale, .second_offset_mag, .second_offset_neg,
        .second_full_scale, .interleave_on, .auto_phase_control,
        .shared_input_choice, .skew_target_select, .coarse_skew_magnitude,
        .fine_skew_magnitude, .frame_done, .frame_bad);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------
    // Expected output model
    // ------------------------------------------------
    function automatic logic [56:0] model(input logic ext);
        logic [15:0] r [16];
        logic        ap;
        if (ext) r = rg;
        else r = rst;
        ap = r[13][14];
        return {r[1][12], r[1][11] & ~r[1][10], r[1][10],
            ext ? r[1][9] : swing_choice_pin, ext ? r[1][8] : edge_choice_pin,
            r[2][15:7], r[3][15:7], r[10][15:7], r[11][15:7], r[13][15:14],
            r[14][15:14], ap ? 3'h0 : r[14][13:11], ap ? 9'h000 : r[15][15:7]};
    endfunction : model

    function automatic logic [15:0] legal(input logic [3:0] a);
        logic [15:0] v;
        v = 16'($urandom);
        case (a)
            ADDR_CFG:           v = {3'b101, v[12:8], 8'hFF};
            ADDR_ILV_EN:        v[13:0] = 14'h3FFF;
            ADDR_COARSE:        v[10:0] = 11'h7FF;
            ADDR_FS1, ADDR_FS2: v = {9'h0C0 + {1'b0, v[15:8]}, 7'h7F};
            default:            v[6:0] = 7'h7F;
        endcase
        return v;
    endfunction : legal

    task automatic check(input logic [58:0] seen, input logic [58:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d,
                      input logic [11:0] h, input bit keep);
        logic bad;
        bad = h !== FRAME_HEADER || !(a inside {adr});
        if (!bad) rg[a] = d;
        exq.push_back({~bad, bad, model(1'b1)});
        u_aecr_host.send({h, a, d}, 32, keep);
    endtask : wr

    task automatic wl(input logic [3:0] a, input bit keep);
        if (a == ADDR_CFG && rg[13][15]) wr(ADDR_ILV_EN, 16'h3FFF, 12'h001, keep);
        wr(a, legal(a), FRAME_HEADER, keep);
    endtask : wl

    task automatic now(input logic ext);
        @(negedge clk_sys);
        check({frame_done, frame_bad, obs}, {2'b00, model(ext)});
        @(posedge clk_sys);
    endtask : now

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    always @(negedge clk_sys) begin
        if (frame_done === 1'b1 || frame_bad === 1'b1) begin
            // Control outputs settle one cycle after the pulse
            pulse = {frame_done, frame_bad};
            @(negedge clk_sys);
            if (exq.size() == 0) check(59'h1, 59'h0);
            else check({pulse, obs}, exq.pop_front());
        end
    end

    initial begin
        #1000000;
        n_fail++;
        conclude();
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        void'($urandom(32'hD9498A10));
        {reset, ext_mode, edge_choice_pin, swing_choice_pin} = 4'hD;
        foreach (rst[i]) rst[i] = 16'hFFFF;
        {rst[1], rst[2], rst[3], rst[10]} = {CFG_RST, OFS_RST, FS_RST, OFS_RST};
        {rst[11], rst[13], rst[14]} = {FS_RST, ILV_EN_RST, COARSE_RST};
        rst[15] = FINE_RST;
        rg = rst;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (6) @(posedge clk_sys);
        now(1'b1);
        // interleave default first, then the other seven registers
        wr(ADDR_ILV_EN, ILV_EN_RST, FRAME_HEADER, 1'b0);
        foreach (adr[i]) if (i > 0) wl(adr[i], 1'b0);
        repeat (24) wl(adr[$urandom_range(7)], 1'b0);
        $display("test random_writes finished");
        wr(ADDR_ILV_EN, 16'hFFFF, FRAME_HEADER, 1'b0);
        wl(ADDR_COARSE, 1'b0);
        wl(ADDR_CFG, 1'b0);
        wr(ADDR_CFG, 16'hBFFF, FRAME_HEADER, 1'b0);
        wr(ADDR_CFG, 16'h0000, 12'h003, 1'b0);
        foreach (rsv[i]) wr(rsv[i], 16'($urandom), FRAME_HEADER, 1'b0);
        $display("test refusals finished");
        u_aecr_host.half = 6;
        repeat (3) wl(adr[$urandom_range(2, 7)], 1'b1);
        u_aecr_host.half = 4;
        u_aecr_host.send({FRAME_HEADER, ADDR_FS1, 16'h0000}, 20, 1'b0);
        wl(ADDR_FS2, 1'b0);
        $display("test back_to_back finished");
        ext_mode <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            {edge_choice_pin, swing_choice_pin} <= 2'(p);
            repeat (6) @(posedge clk_sys);
            now(1'b0);
        end
        u_aecr_host.send({FRAME_HEADER, ADDR_OFS1, 16'hFFFF}, 32, 1'b0);
        repeat (6) @(posedge clk_sys);
        now(1'b0);
        ext_mode <= 1'b1;
        repeat (6) @(posedge clk_sys);
        now(1'b1);
        $display("test normal_mode finished");
        for (int i = 0; i < 400 && exq.size() != 0; i++) @(posedge clk_sys);
        check(59'(exq.size()), 59'h0);
        conclude();
    end
endmodule : test_aecr_top
`default_nettype wire
